// >>> hdl/usip_pkg.sv
/*
  Shared constants for the unit sense and inventory page block: register map,
  page layouts, field codes and reset values.
  Assumes a 32-bit Avalon-MM register bus with byte addresses.
*/
package usip_pkg;

  // Register map, byte addresses
  localparam logic [11:0] CTRL_OFS     = 12'h000;
  localparam logic [11:0] STATUS_OFS   = 12'h004;
  localparam logic [11:0] SENSE_BASE   = 12'h100;
  localparam logic [11:0] INV_BASE     = 12'h400;
  localparam logic [11:0] ID_BASE      = 12'h800;

  // Control and status fields
  localparam int          CTRL_SCAN_BIT   = 0;
  localparam int          CTRL_CLEAR_BIT  = 1;
  localparam int          CTRL_CNTCLR_BIT = 2;
  localparam logic        CTRL_SCAN_RST   = 1'b0;
  localparam int          ST_HELD_BIT     = 0;
  localparam int          ST_OVERRUN_BIT  = 1;
  localparam int          ST_DETECT_LSB   = 2;
  localparam int          ST_SRC_LSB      = 4;
  localparam int          ST_HOSTID_LSB   = 8;
  localparam int          ST_COUNT_LSB    = 16;

  // Page geometry
  localparam int          SENSE_BYTES       = 21;
  localparam int          INV_BYTES         = 241;
  localparam int          DESC_FIRST        = 3;
  localparam int          DESC_BYTES        = 34;
  localparam int          UNIT_COUNT        = 5;
  localparam int          ID_UNITS          = 3;
  localparam int          ID_BYTES_PER_UNIT = 28;
  localparam int          VENDOR_OFS        = 6;
  localparam int          PRODUCT_OFS       = 14;
  localparam int          FW_OFS            = 30;

  // Field codes
  localparam logic [7:0]  SENSE_PAGE_CODE = 8'h28;
  localparam logic [7:0]  SENSE_PAGE_LEN  = 8'h12;
  localparam logic [7:0]  INV_PAGE_CODE   = 8'h29;
  localparam logic [7:0]  INV_PAGE_LEN    = 8'hEF;
  localparam logic [7:0]  MAX_UNIT_NUM    = 8'h04;
  localparam logic [7:0]  ERR_DEFERRED    = 8'h71;
  localparam logic [7:0]  SK_UNIT_ATTN    = 8'h06;
  localparam logic [7:0]  INFO0_CTL       = 8'h0A;
  localparam logic [7:0]  INFO0_DRV       = 8'h0B;
  localparam logic [7:0]  TYPE_DRIVE      = 8'h06;
  localparam logic [7:0]  TYPE_CTL        = 8'h07;
  localparam logic [7:0]  ADD_LEN         = 8'h0B;
  localparam logic [7:0]  UNIT_DRV1       = 8'h01;
  localparam logic [7:0]  UNIT_DRV2       = 8'h02;
  localparam logic [7:0]  STATE_ABSENT    = 8'h00;
  localparam logic [7:0]  STATE_PRESENT   = 8'h01;
  localparam logic [7:0]  STATE_UNKNOWN   = 8'h06;

  typedef enum logic [1:0] {
    USIP_SRC_CTL,
    USIP_SRC_DRV1,
    USIP_SRC_DRV2
  } usip_src_e;

endpackage

// >>> hdl/usip_sense_page.sv
/*
  Byte generator for the unit sense retrieval page, from the held error record.
  Assumes the caller keeps byte_idx_i below the page size.
*/
`timescale 1ns/1ns
module usip_sense_page (
  // Byte select
  input  wire logic               [4:0] byte_idx_i,
  // Held record
  input  wire logic                     held_i,
  input  wire usip_pkg::usip_src_e      src_i,
  input  wire logic               [7:0] panic_i,
  input  wire logic               [3:0] skey_i,
  input  wire logic               [7:0] sks_i,
  input  wire logic              [31:0] csi_i,
  input  wire logic               [7:0] asc_i,
  input  wire logic               [7:0] ascq_i,
  input  wire logic              [23:0] info_i,
  input  wire logic               [1:0] detect_i,
  // Page byte
  output logic                    [7:0] byte_o
);

  logic drv;

  assign drv = (src_i != usip_pkg::USIP_SRC_CTL);

  always_comb
  begin
    byte_o = 8'h00;
    case (byte_idx_i)
      5'h00: byte_o = usip_pkg::SENSE_PAGE_CODE;
      5'h01: byte_o = usip_pkg::SENSE_PAGE_LEN;
      default:
      begin
        // Nothing held: every field past the header reads zero
        if (held_i)
        begin
          case (byte_idx_i)
            5'h02: byte_o = usip_pkg::ERR_DEFERRED;
            5'h04: byte_o = drv ? sks_i : usip_pkg::SK_UNIT_ATTN;
            5'h05: byte_o = drv ? usip_pkg::INFO0_DRV : usip_pkg::INFO0_CTL;
            5'h06: byte_o = drv ? {4'h0, skey_i} : panic_i;
            5'h08: byte_o = drv ? usip_pkg::TYPE_DRIVE : usip_pkg::TYPE_CTL;
            5'h09: byte_o = usip_pkg::ADD_LEN;
            5'h0A: byte_o = drv ? csi_i[31:24] : 8'h00;
            5'h0B: byte_o = drv ? csi_i[23:16] : 8'h00;
            5'h0C: byte_o = drv ? csi_i[15:8] : 8'h00;
            5'h0D: byte_o = drv ? csi_i[7:0] : 8'h00;
            5'h0E: byte_o = drv ? asc_i : 8'h00;
            5'h0F: byte_o = drv ? ascq_i : 8'h00;
            5'h10: byte_o = (src_i == usip_pkg::USIP_SRC_DRV1) ? usip_pkg::UNIT_DRV1 :
                            (src_i == usip_pkg::USIP_SRC_DRV2) ? usip_pkg::UNIT_DRV2 :
                            8'h00;
            5'h12: byte_o = drv ? info_i[23:16] : 8'h00;
            5'h13: byte_o = drv ? info_i[15:8] : 8'h00;
            5'h14: byte_o = drv ? info_i[7:0] : {6'h00, detect_i};
            default: byte_o = 8'h00;
          endcase
        end
      end
    endcase
  end

endmodule

// >>> hdl/usip_inventory.sv
/*
  Unit inventory page: identification table written by software and the
  byte generator for the descriptor page.
  Assumes table indices from the caller stay below the table depth.
*/
`timescale 1ns/1ns
module usip_inventory #(
  parameter int ID_DEPTH = usip_pkg::ID_UNITS * usip_pkg::ID_BYTES_PER_UNIT
) (
  // Clock and reset
  input  wire logic       mclk_i,
  input  wire logic       rst_n_i,
  // Identification table port
  input  wire logic       tbl_we_i,
  input  wire logic [6:0] tbl_idx_i,
  input  wire logic [7:0] tbl_wdata_i,
  output logic      [7:0] tbl_q_o,
  // Page inputs
  input  wire logic [7:0] byte_idx_i,
  input  wire logic       scan_done_i,
  input  wire logic [1:0] detect_i,
  input  wire logic [3:0] host_id_i,
  // Page byte
  output logic      [7:0] byte_o
);

  logic [7:0] id_tbl [ID_DEPTH];
  logic [8:0] rel;
  logic [8:0] unit;
  logic [8:0] off;
  logic [6:0] tidx;

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      for (int i = 0; i < ID_DEPTH; i++)
        id_tbl[i] <= 8'h00;
    end
    else if (tbl_we_i)
      id_tbl[tbl_idx_i] <= tbl_wdata_i;
  end

  assign tbl_q_o = id_tbl[tbl_idx_i];
  assign rel     = {1'b0, byte_idx_i} - 9'(usip_pkg::DESC_FIRST);
  assign unit    = rel / 9'(usip_pkg::DESC_BYTES);
  assign off     = rel % 9'(usip_pkg::DESC_BYTES);
  assign tidx    = 7'(unit * 9'(usip_pkg::ID_BYTES_PER_UNIT) + off
                      - 9'(usip_pkg::VENDOR_OFS));

  always_comb
  begin
    byte_o = 8'h00;
    if (byte_idx_i == 8'h00)
      byte_o = usip_pkg::INV_PAGE_CODE;
    else if (byte_idx_i == 8'h01)
      byte_o = usip_pkg::INV_PAGE_LEN;
    else if (byte_idx_i == 8'h02)
      byte_o = usip_pkg::MAX_UNIT_NUM;
    else if (unit < 9'(usip_pkg::UNIT_COUNT))
    begin
      if (unit >= 9'(usip_pkg::ID_UNITS))
        // Reserved units carry only their number
        byte_o = (off == 9'h000) ? unit[7:0] : 8'h00;
      else
      begin
        case (off)
          9'h000: byte_o = unit[7:0];
          9'h001: byte_o = (unit == 9'h000) ? usip_pkg::TYPE_CTL
                                            : usip_pkg::TYPE_DRIVE;
          9'h002:
          begin
            if (unit == 9'h000)
              byte_o = usip_pkg::STATE_PRESENT;
            else if (!scan_done_i)
              byte_o = usip_pkg::STATE_UNKNOWN;
            else
              byte_o = detect_i[unit[0] ? 0 : 1] ? usip_pkg::STATE_PRESENT
                                                 : usip_pkg::STATE_ABSENT;
          end
          9'h003: byte_o = (unit == 9'h000) ? {4'h0, host_id_i} : unit[7:0];
          default:
          begin
            if (off < 9'(usip_pkg::VENDOR_OFS))
              byte_o = 8'h00;
            else if (off < 9'(usip_pkg::FW_OFS) && unit == 9'h000)
              byte_o = 8'h00;
            else
              byte_o = id_tbl[tidx];
          end
        endcase
      end
    end
  end

endmodule

// >>> hdl/usip_unit_pages.sv
/*
  Unit sense and inventory pages: captures deferred errors from the controller
  and the two tape drives, and serves both diagnostic pages to software.
  Assumes error strobes come from logic on mclk_i; drive detect and host ID
  arrive from pins and are synchronised here.
*/
// What this block does
// - Sense page byte 0 holds page code 28h, top two bits zero.
// - Sense page byte 1 holds length 12h.
// - With no error held, error code and all later fields read zero.
// - A held deferred error shows error code 71h and fills bytes 4 to 20.
// - Controller errors give sense key 6h, info byte 0Ah, then panic code.
// - Drive errors give 0Bh, drive sense key, and its key-specific byte in byte 4.
// - Byte 8 holds unit type 06h for drives, 07h for the controller.
// - Drive sense bytes 8-13 fill page bytes 10-15; controller errors zero them.
// - Byte 16 names the reporter: 01h, 02h for drives, zero for controller.
// - Controller errors show drive detect for channels one and two in byte 20.
// - Inventory page byte 0 holds page code 29h.
// - Inventory page byte 1 holds length EFh.
// - Inventory byte 2 holds the highest unit number, four.
// - One descriptor per unit: number, type, state, position, vendor, product, firmware for units 0-2; number only for 3 and 4.
// - Unit 0 is the controller, 1 and 2 the drives, 3 and 4 reserved.
// - Type byte is 06h for drives, 07h for the controller.
// - State byte is 0 absent, 1 present, 6 unknown.
// - Position is host ID for the controller, drive number for drives.
// - Vendor field is zero for the controller, drive vendor for drives.
// - Product field is zero for the controller, drive product for drives.
`timescale 1ns/1ns
module usip_unit_pages (
  // Clock and reset
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // Avalon-MM slave
  input  wire logic [11:0] avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic  [3:0] avs_byteenable_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  // Controller error report
  input  wire logic        ctl_err_i,
  input  wire logic  [7:0] ctl_panic_i,
  // Drive error report
  input  wire logic        drv_err_i,
  input  wire logic        drv_sel_i,
  input  wire logic  [3:0] drv_sense_key_i,
  input  wire logic  [7:0] drv_sks_i,
  input  wire logic [31:0] drv_csi_i,
  input  wire logic  [7:0] drv_asc_i,
  input  wire logic  [7:0] drv_ascq_i,
  input  wire logic [23:0] drv_info_i,
  // Pins
  input  wire logic  [1:0] drive_detect_i,
  input  wire logic  [3:0] host_scsi_id_i,
  // Status
  output logic             sense_held_o
);

  // Word index of a byte address inside a window
  function automatic logic [9:0] word_index(input logic [11:0] addr,
                                            input logic [11:0] base);
    logic [11:0] diff;
    diff = addr - base;
    return diff[11:2];
  endfunction

  // Pin synchronisers
  logic [1:0] detect_meta;
  logic [1:0] detect_sync;
  logic [3:0] hostid_meta;
  logic [3:0] hostid_sync;

  // Bus decode
  logic        bus_req;
  logic        bus_wr_ok;
  logic [9:0]  sense_widx;
  logic [9:0]  inv_widx;
  logic [9:0]  id_widx;
  logic        hit_sense;
  logic        hit_inv;
  logic        hit_id;
  logic        hit_ctrl;
  logic        hit_status;
  logic [31:0] next_rdata;

  // Control
  logic        scan_done;
  logic        clear_req;
  logic        cnt_clear_req;

  // Held error record
  logic                sense_held;
  logic                overrun;
  logic [7:0]          err_count;
  usip_pkg::usip_src_e src;
  logic [7:0]          panic;
  logic [3:0]          skey;
  logic [7:0]          sks;
  logic [31:0]         csi;
  logic [7:0]          asc;
  logic [7:0]          ascq;
  logic [23:0]         info;
  logic                err_event;

  // Page bytes
  logic [7:0] sense_byte;
  logic [7:0] inv_byte;
  logic [7:0] tbl_q;
  logic       tbl_we;

  // Pins are asynchronous to mclk_i; only the second stage is read
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      detect_meta <= 2'h0;
      detect_sync <= 2'h0;
      hostid_meta <= 4'h0;
      hostid_sync <= 4'h0;
    end
    else
    begin
      detect_meta <= drive_detect_i;
      detect_sync <= detect_meta;
      hostid_meta <= host_scsi_id_i;
      hostid_sync <= hostid_meta;
    end
  end

  assign bus_req    = avs_read_i | avs_write_i;
  assign bus_wr_ok  = avs_write_i & ~avs_waitrequest_o;
  assign sense_widx = word_index(avs_address_i, usip_pkg::SENSE_BASE);
  assign inv_widx   = word_index(avs_address_i, usip_pkg::INV_BASE);
  assign id_widx    = word_index(avs_address_i, usip_pkg::ID_BASE);
  assign hit_ctrl   = (avs_address_i[11:2] == usip_pkg::CTRL_OFS[11:2]);
  assign hit_status = (avs_address_i[11:2] == usip_pkg::STATUS_OFS[11:2]);
  assign hit_sense  = (avs_address_i >= usip_pkg::SENSE_BASE)
                    && (sense_widx < 10'(usip_pkg::SENSE_BYTES));
  assign hit_inv    = (avs_address_i >= usip_pkg::INV_BASE)
                    && (inv_widx < 10'(usip_pkg::INV_BYTES));
  assign hit_id     = (avs_address_i >= usip_pkg::ID_BASE)
                    && (id_widx < 10'(usip_pkg::ID_UNITS * usip_pkg::ID_BYTES_PER_UNIT));

  // Writes take effect at the edge where waitrequest is seen low
  assign clear_req     = bus_wr_ok & hit_ctrl & avs_byteenable_i[0]
                       & avs_writedata_i[usip_pkg::CTRL_CLEAR_BIT];
  assign cnt_clear_req = bus_wr_ok & hit_ctrl & avs_byteenable_i[0]
                       & avs_writedata_i[usip_pkg::CTRL_CNTCLR_BIT];
  // Page windows take no writes; only the identification table does
  assign tbl_we        = bus_wr_ok & hit_id & avs_byteenable_i[0];

  // One wait state on every access, then a single ready cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      avs_waitrequest_o <= 1'b1;
    else if (bus_req && avs_waitrequest_o)
      avs_waitrequest_o <= 1'b0;
    else
      avs_waitrequest_o <= 1'b1;
  end

  always_comb
  begin
    next_rdata = 32'h0000_0000;
    if (hit_ctrl)
      next_rdata[usip_pkg::CTRL_SCAN_BIT] = scan_done;
    else if (hit_status)
    begin
      next_rdata[usip_pkg::ST_HELD_BIT]                          = sense_held;
      next_rdata[usip_pkg::ST_OVERRUN_BIT]                       = overrun;
      next_rdata[usip_pkg::ST_DETECT_LSB +: 2]                   = detect_sync;
      next_rdata[usip_pkg::ST_SRC_LSB +: 2]                      = src;
      next_rdata[usip_pkg::ST_HOSTID_LSB +: 4]                   = hostid_sync;
      next_rdata[usip_pkg::ST_COUNT_LSB +: 8]                    = err_count;
    end
    else if (hit_sense)
      next_rdata[7:0] = sense_byte;
    else if (hit_inv)
      next_rdata[7:0] = inv_byte;
    else if (hit_id)
      next_rdata[7:0] = tbl_q;
  end

  // Read data is loaded while waitrequest is high and stands through the ready cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      avs_readdata_o <= 32'h0000_0000;
    else if (avs_read_i && avs_waitrequest_o)
      avs_readdata_o <= next_rdata;
  end

  // Drive presence is reported as unknown until software finishes its scan
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      scan_done <= usip_pkg::CTRL_SCAN_RST;
    else if (bus_wr_ok && hit_ctrl && avs_byteenable_i[0])
      scan_done <= avs_writedata_i[usip_pkg::CTRL_SCAN_BIT];
  end

  assign err_event = ctl_err_i | drv_err_i;

  // A new error in the clear cycle survives: set wins over clear
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      sense_held <= 1'b0;
    else if (err_event)
      sense_held <= 1'b1;
    else if (clear_req)
      sense_held <= 1'b0;
  end

  // Overrun marks a record replaced before software cleared it
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      overrun <= 1'b0;
    else if (err_event && sense_held && !clear_req)
      overrun <= 1'b1;
    else if (clear_req)
      overrun <= 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      err_count <= 8'h00;
    else if (err_event && err_count != 8'hFF)
      err_count <= err_count + 8'h01;
    else if (cnt_clear_req)
      err_count <= 8'h00;
  end

  // Newest error wins; the controller outranks a drive in the same cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      src   <= usip_pkg::USIP_SRC_CTL;
      panic <= 8'h00;
      skey  <= 4'h0;
      sks   <= 8'h00;
      csi   <= 32'h0000_0000;
      asc   <= 8'h00;
      ascq  <= 8'h00;
      info  <= 24'h00_0000;
    end
    else if (ctl_err_i)
    begin
      src   <= usip_pkg::USIP_SRC_CTL;
      panic <= ctl_panic_i;
    end
    else if (drv_err_i)
    begin
      src   <= drv_sel_i ? usip_pkg::USIP_SRC_DRV2 : usip_pkg::USIP_SRC_DRV1;
      skey  <= drv_sense_key_i;
      sks   <= drv_sks_i;
      csi   <= drv_csi_i;
      asc   <= drv_asc_i;
      ascq  <= drv_ascq_i;
      info  <= drv_info_i;
    end
  end

  assign sense_held_o = sense_held;

  usip_sense_page u_sense (
    .byte_idx_i (sense_widx[4:0]),
    .held_i     (sense_held),
    .src_i      (src),
    .panic_i    (panic),
    .skey_i     (skey),
    .sks_i      (sks),
    .csi_i      (csi),
    .asc_i      (asc),
    .ascq_i     (ascq),
    .info_i     (info),
    .detect_i   (detect_sync),
    .byte_o     (sense_byte)
  );

  usip_inventory u_inv (
    .mclk_i      (mclk_i),
    .rst_n_i     (rst_n_i),
    .tbl_we_i    (tbl_we),
    .tbl_idx_i   (id_widx[6:0]),
    .tbl_wdata_i (avs_writedata_i[7:0]),
    .tbl_q_o     (tbl_q),
    .byte_idx_i  (inv_widx[7:0]),
    .scan_done_i (scan_done),
    .detect_i    (detect_sync),
    .host_id_i   (hostid_sync),
    .byte_o      (inv_byte)
  );

endmodule

// >>> testbench/usip_unit_pages_sva.sv
/*
  Checker for usip_unit_pages: bus wait timing, error capture and fixed page bytes.
  Assumes it sees only the top ports and is attached by the bind below.
*/
`timescale 1ns/1ns
module usip_unit_pages_sva (
  // Clock and reset
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  // Bus
  input wire logic [11:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  // Errors
  input wire logic        ctl_err_i,
  input wire logic        drv_err_i,
  input wire logic        sense_held_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_req;
    (avs_read_i || avs_write_i) && avs_waitrequest_o;
  endsequence
  sequence s_done;
    !avs_waitrequest_o ##1 avs_waitrequest_o;
  endsequence
  sequence s_ans(a);
    avs_read_i && !avs_waitrequest_o && avs_address_i == a;
  endsequence

  a_wait_once: assert property (s_req |=> s_done)
    else $error("wait state count wrong");
  a_idle_wait: assert property (!avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("answer without request");
  a_held_set: assert property (ctl_err_i || drv_err_i |=> sense_held_o)
    else $error("error not held");
  a_held_keep: assert property (sense_held_o && !(avs_write_i && !avs_waitrequest_o) |=> sense_held_o)
    else $error("held record lost");
  a_sense_code: assert property (s_ans(12'h100) |-> avs_readdata_o == 32'h00000028)
    else $error("sense page code");
  a_sense_len: assert property (s_ans(12'h104) |-> avs_readdata_o == 32'h00000012)
    else $error("sense page length");
  a_inv_code: assert property (s_ans(12'h400) |-> avs_readdata_o == 32'h00000029)
    else $error("inventory page code");
  a_inv_len: assert property (s_ans(12'h404) |-> avs_readdata_o == 32'h000000EF)
    else $error("inventory page length");
  a_inv_max: assert property (s_ans(12'h408) |-> avs_readdata_o == 32'h00000004)
    else $error("highest unit number");
  a_empty_zero: assert property (avs_read_i && !avs_waitrequest_o && avs_address_i >= 12'h108
      && avs_address_i < 12'h154 && !sense_held_o && !$past(sense_held_o) |-> avs_readdata_o == 0)
    else $error("empty page byte not zero");
  a_upper_zero: assert property (avs_read_i && !avs_waitrequest_o
      && (avs_address_i[11:8] == 4'h1 || avs_address_i[11:10] == 2'b01) |-> avs_readdata_o[31:8] == 0)
    else $error("upper page bits not zero");
endmodule

bind usip_unit_pages usip_unit_pages_sva chk (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_readdata_o, .avs_waitrequest_o, .ctl_err_i, .drv_err_i, .sense_held_o);

// >>> testbench/usip_err_model.sv
/*
  Error reporter model: one-cycle controller and drive strobes with their record.
  Assumes the bench raises a go line for one cycle per error.
*/
`timescale 1ns/1ns
module usip_err_model (
  // Clock
  input  wire logic        mclk_i,
  // Bench commands
  input  wire logic        go_ctl_i,
  input  wire logic        go_drv_i,
  input  wire logic        sel_i,
  input  wire logic  [7:0] panic_i,
  input  wire logic [83:0] pay_i,
  // Strobes and record
  output logic             ctl_err_o = 1'b0,
  output logic             drv_err_o = 1'b0,
  output logic             drv_sel_o = 1'b0,
  output logic       [7:0] ctl_panic_o = 8'h00,
  output logic      [83:0] pay_o = '0
);
  // Record lines carry inverted data off the strobe, so late sampling shows up
  always @(posedge mclk_i)
  begin
    ctl_err_o   <= go_ctl_i;
    drv_err_o   <= go_drv_i;
    drv_sel_o   <= go_drv_i ? sel_i : ~sel_i;
    ctl_panic_o <= go_ctl_i ? panic_i : ~panic_i;
    pay_o       <= go_drv_i ? pay_i : ~pay_i;
  end
endmodule

// >>> testbench/test_usip_unit_pages.sv
/*
  Self-checking bench for usip_unit_pages over Avalon-MM.
  Assumes the error model drives the strobes and pins are static.
*/
`timescale 1ns/1ns
module test_usip_unit_pages;
  localparam logic [83:0] PAY = {4'h3, 8'h5C, 32'h11223344, 8'h55, 8'h66, 24'h778899};
  logic        mclk_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [11:0] avs_address_i = 12'h000;
  logic        avs_read_i = 1'b0;
  logic        avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h00000000;
  logic [31:0] avs_readdata_o;
  logic        avs_waitrequest_o, ctl_err_i, drv_err_i, drv_sel_i, sense_held_o;
  logic  [7:0] ctl_panic_i;
  logic [83:0] pay;
  logic        go_ctl = 1'b0;
  logic        go_drv = 1'b0;
  logic        sel = 1'b0;
  logic  [7:0] e [21];
  int          n_errors = 0;
  int          checked = 0;

  always #5 mclk_i = ~mclk_i;

  usip_err_model model (.mclk_i, .go_ctl_i(go_ctl), .go_drv_i(go_drv), .sel_i(sel),
    .panic_i(8'hA5), .pay_i(PAY), .ctl_err_o(ctl_err_i), .drv_err_o(drv_err_i),
    .drv_sel_o(drv_sel_i), .ctl_panic_o(ctl_panic_i), .pay_o(pay));

  usip_unit_pages dut (.mclk_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i,
    .avs_byteenable_i(4'hF), .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .ctl_err_i, .ctl_panic_i, .drv_err_i, .drv_sel_i, .drv_sense_key_i(pay[83:80]),
    .drv_sks_i(pay[79:72]), .drv_csi_i(pay[71:40]), .drv_asc_i(pay[39:32]),
    .drv_ascq_i(pay[31:24]), .drv_info_i(pay[23:0]), .drive_detect_i(2'b01),
    .host_scsi_id_i(4'h5), .sense_held_o);

  task results();
    $display("TB: checked %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input string w, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", w, exp, got);
    end
  endtask

  // Waits an edge first so a release and the next request never share a time step
  // Only the watchdog ends a wait that never sees waitrequest low
  task xfer(input logic wr, input logic [11:0] a, input logic [7:0] wd, output logic [31:0] d);
    @(posedge mclk_i);
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, wd};
    avs_read_i <= !wr;
    avs_write_i <= wr;
    do
      @(posedge mclk_i);
    while (avs_waitrequest_o !== 1'b0);
    d = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task rchk(input string w, input logic [11:0] a, input logic [7:0] exp);
    logic [31:0] d;
    xfer(1'b0, a, 8'h00, d);
    chk(w, {24'h000000, exp}, d);
  endtask

  task e_base();
    e = '{default: 8'h00};
    e[0] = 8'h28;
    e[1] = 8'h12;
  endtask

  task sense_cmp(input string w);
    for (int n = 0; n < 21; n++)
      rchk(w, usip_pkg::SENSE_BASE + 12'(4 * n), e[n]);
  endtask

  task fire(input logic c, input logic s);
    @(posedge mclk_i);
    go_ctl <= c;
    go_drv <= !c;
    sel <= s;
    @(posedge mclk_i);
    go_ctl <= 1'b0;
    go_drv <= 1'b0;
    repeat (2) @(posedge mclk_i);
    chk("held", 32'h00000001, {31'h0, sense_held_o});
  endtask

  task t_empty();
    e_base();
    sense_cmp("empty");
    $display("TB: empty page done");
  endtask

  task t_ctl();
    logic [31:0] d;
    fire(1'b1, 1'b0);
    xfer(1'b1, usip_pkg::SENSE_BASE, 8'hFF, d);
    e_base();
    e[2] = 8'h71;
    e[4] = 8'h06;
    e[5] = 8'h0A;
    e[6] = 8'hA5;
    e[8] = 8'h07;
    e[9] = 8'h0B;
    e[20] = 8'h01;
    sense_cmp("ctl");
    $display("TB: controller error done");
  endtask

  task t_drv(input logic s);
    fire(1'b0, s);
    e_base();
    e[2] = 8'h71;
    e[4] = 8'h5C;
    e[5] = 8'h0B;
    e[6] = 8'h03;
    e[8] = 8'h06;
    e[9] = 8'h0B;
    for (int i = 0; i < 6; i++)
      e[10 + i] = 8'((i + 1) * 17);
    e[16] = 8'(s) + 8'h01;
    for (int i = 0; i < 3; i++)
      e[18 + i] = 8'((i + 7) * 17);
    sense_cmp("drv");
    $display("TB: drive error done");
  endtask

  function automatic logic [7:0] inv_exp(int b, logic scan);
    int u;
    int o;
    if (b < 3)
      return b == 0 ? 8'h29 : b == 1 ? 8'hEF : 8'h04;
    u = (b - 3) / 34;
    o = (b - 3) % 34;
    if (u > 4)
      return 8'h00;
    if (o == 0)
      return 8'(u);
    if (u > 2)
      return 8'h00;
    if (o == 1)
      return u == 0 ? 8'h07 : 8'h06;
    if (o == 2)
      return u == 0 ? 8'h01 : !scan ? 8'h06 : u == 1 ? 8'h01 : 8'h00;
    if (o == 3)
      return u == 0 ? 8'h05 : 8'(u);
    if (u == 1 && o == 6)
      return 8'h41;
    if (u == 2 && o == 14)
      return 8'h42;
    return (u == 0 && o == 30) ? 8'h43 : 8'h00;
  endfunction

  task t_inv();
    logic [31:0] d;
    // Held, overrun, detect 01, source drive two, host ID 5, three errors counted
    xfer(1'b0, 12'h004, 8'h00, d);
    chk("status", 32'h00030527, d);
    xfer(1'b1, 12'h000, 8'h02, d);
    // The clear lands at the answer edge; look one edge later
    @(posedge mclk_i);
    chk("cleared", 32'h00000000, {31'h0, sense_held_o});
    t_empty();
    xfer(1'b1, 12'h870, 8'h41, d);
    xfer(1'b1, 12'h900, 8'h42, d);
    xfer(1'b1, 12'h860, 8'h43, d);
    xfer(1'b1, usip_pkg::INV_BASE, 8'hFF, d);
    rchk("unmapped", 12'hFFC, 8'h00);
    for (int s = 0; s < 2; s++)
    begin
      xfer(1'b1, 12'h000, 8'(s), d);
      for (int b = 0; b < 241; b++)
        rchk("inv", usip_pkg::INV_BASE + 12'(4 * b), inv_exp(b, s[0]));
    end
    $display("TB: inventory done");
  endtask

  initial
  begin
    repeat (8) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    t_empty();
    t_ctl();
    t_drv(1'b0);
    t_drv(1'b1);
    t_inv();
    results();
  end

  initial
  begin
    #200000;
    n_errors++;
    results();
  end
endmodule
